// *** verilog/poe_port_mode_control.sv ***
// Purpose: per-port operating mode control, detect/class sequencing and power removal
// Assumes: measurement results and faults come from logic on clk_i
// Notes:   standalone and midspan pins are captured once, when reset releases
`timescale 1ns/100ps
`default_nettype none
// Operation
// - two-bit mode per port: shutdown, manual, semi-auto, standalone or reserved.
// - manual port idles, runs one detect or class on command, records result.
// - manual port powers on or off on host order, no detection needed.
// - semi-auto port cycles detection and enabled classification, reporting each result.
// - semi-auto port never powers itself; only a host power-on command does.
// - standalone mode cycles like semi-auto, self-powers after good detect, loads thresholds.
// - shutdown port does no detection, no classification, never applies power.
// - any mode: current-limit fault removes port power.
// - any mode: enabled disconnect sensing plus disconnect event removes port power.
// - any mode: host power-off command removes port power.
// - full reset on reset input or global reset-all control.
// - configuration follows pin levels sampled at reset; later changes wait for reset.
// - standalone class 1/2/3/0 overload 112/206/375 mA, limit 425 mA.
// - standalone class 4 overload 638 mA, limit 850 mA.
// - thresholds load automatically only when last reset saw standalone pin high.
// - sense resistor defaults to 0.5 ohm, or 0.25 ohm with standalone high.
// - sense resistor setting stays writable any time after reset.
// - legacy ac disconnect enable bits mirror dc disconnect enable bits.
// - midspan pin high at reset selects midspan timing; standalone runs without host.
// - semi-auto waits at least 100 ms, or 2 s midspan, before redetecting.
// - semi-auto high-power power-on needs good detection, else startup fault.
module poe_port_mode_control
   import poe_mode_pkg::*;
#(
   parameter int NUM_PORTS       = PORTS,
   parameter int BACKOFF_CYC     = BACKOFF_MS * CYC_PER_MS,
   parameter int MID_BACKOFF_CYC = MID_BACKOFF_MS * CYC_PER_MS
) (
   input  wire logic                          clk_i,
   input  wire logic                          srst_i,
   input  wire logic                          reset_all_i,
   input  wire logic                          standalone_pin_i,
   input  wire logic                          midspan_pin_i,
   input  wire logic [NUM_PORTS-1:0][1:0]     port_mode_field_i,
   input  wire logic [NUM_PORTS-1:0]          detect_en_i,
   input  wire logic [NUM_PORTS-1:0]          class_en_i,
   input  wire logic [NUM_PORTS-1:0]          high_power_en_i,
   input  wire logic                          dc_disc_wr_i,
   input  wire logic                          ac_disc_wr_i,
   input  wire logic [NUM_PORTS-1:0]          disc_wdata_i,
   input  wire logic                          sense_wr_i,
   input  wire logic                          sense_wdata_i,
   input  wire port_cmd_s  [NUM_PORTS-1:0]    cmd_i,
   input  wire port_meas_s [NUM_PORTS-1:0]    meas_i,
   output var  logic [NUM_PORTS-1:0]          power_on_o,
   output var  logic [NUM_PORTS-1:0]          detect_start_o,
   output var  logic [NUM_PORTS-1:0]          class_start_o,
   output var  logic [NUM_PORTS-1:0]          startup_fault_o,
   output var  logic [NUM_PORTS-1:0][2:0]     detect_status_o,
   output var  logic [NUM_PORTS-1:0][2:0]     class_status_o,
   output var  logic [NUM_PORTS-1:0][9:0]     overload_threshold_o,
   output var  logic [NUM_PORTS-1:0][9:0]     current_limit_threshold_o,
   output var  logic [NUM_PORTS-1:0]          dc_disc_en_o,
   output var  logic [NUM_PORTS-1:0]          ac_disc_en_o,
   output var  logic                          sense_quarter_ohm_o,
   output var  logic                          standalone_mode_o,
   output var  logic                          midspan_timing_o
);

   if (NUM_PORTS < 1 || NUM_PORTS > 16) begin : g_ports_check
      $error("NUM_PORTS out of range");
   end
   if (BACKOFF_CYC < 1 || MID_BACKOFF_CYC < 1 ||
       BACKOFF_CYC > (1 << (TIMER_W - 1)) || MID_BACKOFF_CYC > (1 << (TIMER_W - 1))) begin : g_cyc_check
      $error("backoff counts do not fit the timer");
   end

   localparam logic [TIMER_W-1:0] BACKOFF_LOAD     = TIMER_W'(BACKOFF_CYC - 1);
   localparam logic [TIMER_W-1:0] MID_BACKOFF_LOAD = TIMER_W'(MID_BACKOFF_CYC - 1);

   typedef struct packed {
      logic                        in_reset;
      logic                        standalone;
      logic                        midspan;
      logic                        sense_quarter;
      port_s [NUM_PORTS-1:0]       port;
   } state_s;

   state_s cur;
   state_s next_cur;
   logic   rst;
   logic   standalone_sync;
   logic   midspan_sync;

   // one full reset for the reset input and the global reset-all control
   assign rst = srst_i | reset_all_i;

   sync_2ff #(
      .WIDTH (2)
   ) u_pin_sync (
      .clk_i (clk_i),
      .d_i   ({standalone_pin_i, midspan_pin_i}),
      .q_o   ({standalone_sync, midspan_sync})
   );

   function automatic logic [19:0] thresholds_for(input logic [2:0] cls);
      case (cls)
         CLASS_1: return {ICUT_CLASS1, CURRENT_LIMIT_THRESHOLD_TYPE1};
         CLASS_2: return {ICUT_CLASS2, CURRENT_LIMIT_THRESHOLD_TYPE1};
         CLASS_4: return {ICUT_CLASS4, CURRENT_LIMIT_THRESHOLD_CLASS4};
         default: return {ICUT_CLASS3, CURRENT_LIMIT_THRESHOLD_TYPE1};
      endcase
   endfunction : thresholds_for

   always_comb begin
      logic [1:0] mode;
      logic       auto_ok;
      logic       active;
      logic       run;
      logic       cls_on;
      logic       kill;
      mode    = MODE_SHUTDOWN;
      auto_ok = 1'b0;
      active  = 1'b0;
      run     = 1'b0;
      cls_on  = 1'b0;
      kill    = 1'b0;
      next_cur = cur;
      if (cur.in_reset) begin
         // capture happens on the first cycle out of reset only
         next_cur.in_reset      = 1'b0;
         next_cur.standalone    = standalone_sync;
         next_cur.midspan       = midspan_sync;
         next_cur.sense_quarter = standalone_sync ? SENSE_QUARTER_OHM : SENSE_HALF_OHM;
      end else if (sense_wr_i) begin
         next_cur.sense_quarter = sense_wdata_i;
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
         mode = port_mode_field_i[p];
         // standalone encoding only counts when the captured pin was high
         auto_ok = (mode == MODE_AUTO) && cur.standalone;
         active  = (mode == MODE_MANUAL) || (mode == MODE_SEMI) || auto_ok;
         // standalone runs with no host, so its enables are implied
         run    = ((mode == MODE_SEMI) && detect_en_i[p]) || auto_ok;
         cls_on = class_en_i[p] || auto_ok;
         next_cur.port[p].det_start     = 1'b0;
         next_cur.port[p].class_start   = 1'b0;
         next_cur.port[p].startup_fault = 1'b0;
         if (cur.in_reset) begin
            next_cur.port[p].disc_en = standalone_sync;
         end else if (dc_disc_wr_i || ac_disc_wr_i) begin
            next_cur.port[p].disc_en = disc_wdata_i[p];
         end
         case (cur.port[p].st)
            ST_IDLE: begin
               if (!active || cur.in_reset) begin
                  next_cur.port[p].st = ST_IDLE;
               end else if (mode == MODE_MANUAL) begin
                  if (cmd_i[p].detect) begin
                     next_cur.port[p].st        = ST_DETECT;
                     next_cur.port[p].det_start = 1'b1;
                  end else if (cmd_i[p].classify) begin
                     next_cur.port[p].st          = ST_CLASS;
                     next_cur.port[p].class_start = 1'b1;
                  end
               end else if (run && !cur.port[p].power) begin
                  next_cur.port[p].st        = ST_DETECT;
                  next_cur.port[p].det_start = 1'b1;
               end
            end
            ST_DETECT: begin
               if (meas_i[p].det_done) begin
                  next_cur.port[p].det_status = meas_i[p].det_result;
                  if (mode == MODE_MANUAL) begin
                     next_cur.port[p].st = ST_IDLE;
                  end else if (meas_i[p].det_result == DET_GOOD && cls_on) begin
                     next_cur.port[p].st          = ST_CLASS;
                     next_cur.port[p].class_start = 1'b1;
                  end else if (meas_i[p].det_result == DET_GOOD && auto_ok) begin
                     next_cur.port[p].st    = ST_IDLE;
                     next_cur.port[p].power = 1'b1;
                  end else begin
                     next_cur.port[p].st    = ST_BACKOFF;
                     next_cur.port[p].timer = cur.midspan ? MID_BACKOFF_LOAD : BACKOFF_LOAD;
                  end
               end
            end
            ST_CLASS: begin
               if (meas_i[p].class_done) begin
                  next_cur.port[p].class_status = meas_i[p].class_result;
                  if (mode == MODE_MANUAL) begin
                     next_cur.port[p].st = ST_IDLE;
                  end else if (auto_ok) begin
                     next_cur.port[p].st    = ST_IDLE;
                     next_cur.port[p].power = 1'b1;
                     {next_cur.port[p].icut, next_cur.port[p].current_limit_threshold} =
                        thresholds_for(meas_i[p].class_result);
                  end else begin
                     next_cur.port[p].st    = ST_BACKOFF;
                     next_cur.port[p].timer = cur.midspan ? MID_BACKOFF_LOAD : BACKOFF_LOAD;
                  end
               end
            end
            ST_BACKOFF: begin
               if (cur.port[p].timer == '0) begin
                  next_cur.port[p].st = ST_IDLE;
               end else begin
                  next_cur.port[p].timer = cur.port[p].timer - 1'b1;
               end
            end
            default: begin
               next_cur.port[p].st = ST_IDLE;
            end
         endcase
         // leaving an active mode abandons any measurement in flight
         if (!active) begin
            next_cur.port[p].st = ST_IDLE;
         end
         if (cmd_i[p].power_on && (mode == MODE_MANUAL || mode == MODE_SEMI)) begin
            if (mode == MODE_SEMI && high_power_en_i[p] && cur.port[p].det_status != DET_GOOD) begin
               next_cur.port[p].startup_fault = 1'b1;
            end else begin
               next_cur.port[p].power = 1'b1;
            end
         end
         // removal wins over any power-on raised in the same cycle
         kill = !active || meas_i[p].current_limit_fault ||
                (cur.port[p].disc_en && meas_i[p].disconnect) || cmd_i[p].power_off;
         if (kill) begin
            next_cur.port[p].power = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst) begin
         cur          <= '0;
         cur.in_reset <= 1'b1;
         for (int p = 0; p < NUM_PORTS; p++) begin
            cur.port[p].st           <= ST_IDLE;
            cur.port[p].det_status   <= DET_UNKNOWN;
            cur.port[p].class_status <= CLASS_0;
            cur.port[p].icut         <= ICUT_RESET;
            cur.port[p].current_limit_threshold         <= CURRENT_LIMIT_THRESHOLD_RESET;
         end
      end else begin
         cur <= next_cur;
      end
   end

   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         power_on_o[p]                = cur.port[p].power;
         detect_start_o[p]            = cur.port[p].det_start;
         class_start_o[p]             = cur.port[p].class_start;
         startup_fault_o[p]           = cur.port[p].startup_fault;
         detect_status_o[p]           = cur.port[p].det_status;
         class_status_o[p]            = cur.port[p].class_status;
         overload_threshold_o[p]      = cur.port[p].icut;
         current_limit_threshold_o[p] = cur.port[p].current_limit_threshold;
         dc_disc_en_o[p]              = cur.port[p].disc_en;
         ac_disc_en_o[p]              = cur.port[p].disc_en;
      end
   end

   assign sense_quarter_ohm_o = cur.sense_quarter;
   assign standalone_mode_o   = cur.standalone;
   assign midspan_timing_o    = cur.midspan;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst);

   for (genvar g = 0; g < NUM_PORTS; g++) begin : g_chk
      shutdown_no_power_a: assert property (
         port_mode_field_i[g] == MODE_SHUTDOWN |=> !power_on_o[g] && !detect_start_o[g])
         else $error("shutdown port powered or detecting");
      limit_fault_off_a: assert property (
         meas_i[g].current_limit_fault |=> !power_on_o[g])
         else $error("power stayed on after current-limit fault");
      disconnect_off_a: assert property (
         dc_disc_en_o[g] && meas_i[g].disconnect |=> !power_on_o[g])
         else $error("power stayed on after disconnect");
      host_off_a: assert property (
         cmd_i[g].power_off |=> !power_on_o[g])
         else $error("power-off command ignored");
      semi_no_self_a: assert property (
         !power_on_o[g] && port_mode_field_i[g] == MODE_SEMI && !cmd_i[g].power_on
         |=> !power_on_o[g])
         else $error("semi-auto port powered itself");
      manual_on_a: assert property (
         port_mode_field_i[g] == MODE_MANUAL && cmd_i[g].power_on && !cmd_i[g].power_off &&
         !meas_i[g].current_limit_fault && !(dc_disc_en_o[g] && meas_i[g].disconnect)
         |=> power_on_o[g])
         else $error("manual power-on not applied");
      startup_fault_a: assert property (
         port_mode_field_i[g] == MODE_SEMI && high_power_en_i[g] && cmd_i[g].power_on &&
         detect_status_o[g] != DET_GOOD && !power_on_o[g]
         |=> startup_fault_o[g] && !power_on_o[g])
         else $error("startup fault missing on bad detection");
      reserved_idle_a: assert property (
         port_mode_field_i[g] == MODE_AUTO && !standalone_mode_o
         |=> !power_on_o[g] && !detect_start_o[g] && !class_start_o[g])
         else $error("reserved mode port active");
      // a class result counts only while the port waits in its class step
      auto_class4_a: assert property (
         port_mode_field_i[g] == MODE_AUTO && standalone_mode_o && cur.port[g].st == ST_CLASS &&
         meas_i[g].class_done && meas_i[g].class_result == CLASS_4
         |=> overload_threshold_o[g] == ICUT_CLASS4 && current_limit_threshold_o[g] == CURRENT_LIMIT_THRESHOLD_CLASS4)
         else $error("class 4 thresholds not loaded");
      semi_power_c: cover property (
         port_mode_field_i[g] == MODE_SEMI && cmd_i[g].power_on ##1 power_on_o[g]);
      auto_power_c: cover property (
         port_mode_field_i[g] == MODE_AUTO && !power_on_o[g] ##1 power_on_o[g]);
      startup_fault_c: cover property (startup_fault_o[g]);
   end

endmodule : poe_port_mode_control
`default_nettype wire

// *** verilog/poe_mode_pkg.sv ***
// Purpose: shared constants and carriers for the per-port mode control block
// Assumes: 250 MHz core clock, four ports
// Notes:   thresholds are carried in milliamps, detection and class codes in 3 bits
package poe_mode_pkg;

   localparam int PORTS = 4;

   // port mode field encodings
   localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
   localparam logic [1:0] MODE_MANUAL   = 2'h1;
   localparam logic [1:0] MODE_SEMI     = 2'h2;
   localparam logic [1:0] MODE_AUTO     = 2'h3;

   // detection result codes
   localparam logic [2:0] DET_UNKNOWN = 3'h0;
   localparam logic [2:0] DET_GOOD    = 3'h4;

   // class result codes
   localparam logic [2:0] CLASS_0 = 3'h0;
   localparam logic [2:0] CLASS_1 = 3'h1;
   localparam logic [2:0] CLASS_2 = 3'h2;
   localparam logic [2:0] CLASS_3 = 3'h3;
   localparam logic [2:0] CLASS_4 = 3'h4;

   // thresholds in milliamps
   localparam logic [9:0] ICUT_CLASS1 = 10'h070;
   localparam logic [9:0] ICUT_CLASS2 = 10'h0ce;
   localparam logic [9:0] ICUT_CLASS3 = 10'h177;
   localparam logic [9:0] ICUT_CLASS4 = 10'h27e;
   localparam logic [9:0] CURRENT_LIMIT_THRESHOLD_TYPE1  = 10'h1a9;
   localparam logic [9:0] CURRENT_LIMIT_THRESHOLD_CLASS4 = 10'h352;
   localparam logic [9:0] ICUT_RESET  = 10'h177;
   localparam logic [9:0] CURRENT_LIMIT_THRESHOLD_RESET  = 10'h1a9;

   // sense resistor setting
   localparam logic SENSE_HALF_OHM    = 1'b0;
   localparam logic SENSE_QUARTER_OHM = 1'b1;

   // backoff timing
   localparam int CLK_MHZ        = 250;
   localparam int CYC_PER_MS     = CLK_MHZ * 1000;
   localparam int BACKOFF_MS     = 100;
   localparam int MID_BACKOFF_MS = 2000;
   localparam int TIMER_W        = 29;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DETECT,
      ST_CLASS,
      ST_BACKOFF
   } port_state_e;

   typedef struct packed {
      logic detect;
      logic classify;
      logic power_on;
      logic power_off;
   } port_cmd_s;

   typedef struct packed {
      logic       det_done;
      logic [2:0] det_result;
      logic       class_done;
      logic [2:0] class_result;
      logic       current_limit_fault;
      logic       disconnect;
   } port_meas_s;

   typedef struct packed {
      port_state_e        st;
      logic [TIMER_W-1:0] timer;
      logic               power;
      logic               det_start;
      logic               class_start;
      logic               startup_fault;
      logic [2:0]         det_status;
      logic [2:0]         class_status;
      logic [9:0]         icut;
      logic [9:0]         current_limit_threshold;
      logic               disc_en;
   } port_s;

endpackage : poe_mode_pkg

// *** verilog/sync_2ff.sv ***
// Purpose: two flip-flop synchroniser for asynchronous pin levels
// Assumes: levels only, held far longer than two clock periods
// Notes:   no reset so the pin is already settled when the block leaves reset
`timescale 1ns/100ps
`default_nettype none
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_i,
   input  wire logic [WIDTH-1:0] d_i,
   output var  logic [WIDTH-1:0] q_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_s;

   sync_state_s cur;
   sync_state_s next_cur;

   always_comb begin
      next_cur        = cur;
      next_cur.meta   = d_i;
      next_cur.stable = cur.meta;
   end

   always_ff @(posedge clk_i) begin
      cur <= next_cur;
   end

   assign q_o = cur.stable;

endmodule : sync_2ff
`default_nettype wire

// *** verification/pd_front_model.sv ***
// Purpose: measurement front end stand-in that answers detect and class start pulses
// Assumes: one measurement in flight per port, delay shared by all ports
// Notes:   result lines carry the inverse value outside done pulses, so stale data misleads
`timescale 1ns/100ps
`default_nettype none
module pd_front_model
   import poe_mode_pkg::*;
(
   input  wire logic                   clk_i,
   input  wire logic [PORTS-1:0]       det_start_i,
   input  wire logic [PORTS-1:0]       class_start_i,
   input  wire logic [PORTS-1:0][2:0]  det_res_i,
   input  wire logic [PORTS-1:0][2:0]  class_res_i,
   input  wire logic [3:0]             delay_i,
   input  wire logic [PORTS-1:0]       fault_i,
   input  wire logic [PORTS-1:0]       disc_i,
   output var  port_meas_s [PORTS-1:0] meas_o
);
   int dcnt [PORTS];
   int ccnt [PORTS];
   always @(posedge clk_i) begin
      for (int p = 0; p < PORTS; p++) begin
         meas_o[p].det_done <= (dcnt[p] == 1);
         meas_o[p].det_result <= (dcnt[p] == 1) ? det_res_i[p] : ~det_res_i[p];
         meas_o[p].class_done <= (ccnt[p] == 1);
         meas_o[p].class_result <= (ccnt[p] == 1) ? class_res_i[p] : ~class_res_i[p];
         meas_o[p].current_limit_fault <= fault_i[p];
         meas_o[p].disconnect <= disc_i[p];
         dcnt[p] <= det_start_i[p] ? delay_i + 1 : (dcnt[p] > 0 ? dcnt[p] - 1 : 0);
         ccnt[p] <= class_start_i[p] ? delay_i + 1 : (ccnt[p] > 0 ? ccnt[p] - 1 : 0);
      end
   end
endmodule : pd_front_model
`default_nettype wire

// *** verification/test_poe_port_mode_control.sv ***
// Purpose: self-checking bench for per-port mode control
// Assumes: backoff counts cut to 20 and 40 cycles so retries fit the run
// Notes:   standalone threshold expectations come from the class table below; the backoff spacing check and two direct checks read the block's midspan_timing_o
`timescale 1ns/100ps
`default_nettype none
module test_poe_port_mode_control
   import poe_mode_pkg::*;
;
   localparam int BOFF = 20;
   logic                   clk_i = 1'b0, srst_i = 1'b1, reset_all_i = 1'b0;
   logic                   standalone_pin_i = 1'b0, midspan_pin_i = 1'b0;
   logic [PORTS-1:0][1:0]  port_mode_field_i = '0;
   logic [PORTS-1:0]       detect_en_i = '0, class_en_i = '0, high_power_en_i = '0;
   logic                   dc_disc_wr_i = 1'b0, ac_disc_wr_i = 1'b0;
   logic                   sense_wr_i = 1'b0, sense_wdata_i = 1'b0;
   logic [PORTS-1:0]       disc_wdata_i = '0, flt = '0, dsc = '0;
   port_cmd_s [PORTS-1:0]  cmd_i = '0;
   port_meas_s [PORTS-1:0] meas_i;
   logic [PORTS-1:0][2:0]  dres = '0, cres = '0, detect_status_o, class_status_o;
   logic [PORTS-1:0][9:0]  overload_threshold_o, current_limit_threshold_o;
   logic [PORTS-1:0]       power_on_o, detect_start_o, class_start_o;
   logic [PORTS-1:0]       startup_fault_o, dc_disc_en_o, ac_disc_en_o;
   logic                   sense_quarter_ohm_o, standalone_mode_o, midspan_timing_o;
   logic [3:0]             dly = 4'h3;
   int                     mismatches = 0, n_tests = 0, cyc = 0;
   int                     nst [PORTS];
   int                     last [PORTS];

   poe_port_mode_control #(.BACKOFF_CYC(BOFF), .MID_BACKOFF_CYC(2 * BOFF)) dut (
      .clk_i, .srst_i, .reset_all_i, .standalone_pin_i, .midspan_pin_i, .port_mode_field_i,
      .detect_en_i, .class_en_i, .high_power_en_i, .dc_disc_wr_i, .ac_disc_wr_i,
      .disc_wdata_i, .sense_wr_i, .sense_wdata_i, .cmd_i, .meas_i, .power_on_o,
      .detect_start_o, .class_start_o, .startup_fault_o, .detect_status_o, .class_status_o,
      .overload_threshold_o, .current_limit_threshold_o, .dc_disc_en_o, .ac_disc_en_o,
      .sense_quarter_ohm_o, .standalone_mode_o, .midspan_timing_o);
   pd_front_model pdm (.clk_i, .det_start_i(detect_start_o), .class_start_i(class_start_o),
      .det_res_i(dres), .class_res_i(cres), .delay_i(dly), .fault_i(flt), .disc_i(dsc),
      .meas_o(meas_i));

   always #2 clk_i = ~clk_i;

   // sampled on the falling edge so registered outputs have settled
   always @(negedge clk_i) begin
      cyc <= cyc + 1;
      for (int p = 0; p < PORTS; p++) begin
         if (srst_i || reset_all_i) begin
            last[p] <= 0;
         end else if (detect_start_o[p] === 1'b1) begin
            nst[p] <= nst[p] + 1;
            last[p] <= cyc;
            if (last[p] > 0) chk_v(10'(cyc - last[p] > (midspan_timing_o ? 2 * BOFF : BOFF)), 10'h001);
         end
      end
   end

   task automatic chk_v(input logic [9:0] got, input logic [9:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_v

   task automatic print_verdict();
      $display("tests=%0d mismatches=%0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick

   task automatic settle(input int n);
      tick(n);
      @(negedge clk_i);
   endtask : settle

   // which: 0 detect, 1 classify, 2 power on, 3 power off
   task automatic send(input int p, input int which);
      tick(1);
      cmd_i[p] <= port_cmd_s'(4'h8 >> which);
      tick(1);
      cmd_i[p] <= '0;
      @(negedge clk_i);
   endtask : send

   // what: 0 detect start, 1 class start, 2 power
   task automatic wait_for(input logic [PORTS-1:0] m, input int what);
      int k;
      k = 0;
      while (k < 400 && ((what == 0 ? detect_start_o : what == 1 ? class_start_o : power_on_o) & m) !== m) begin
         @(negedge clk_i);
         k++;
      end
      if (k == 400) begin
         mismatches++;
         print_verdict();
      end
   endtask : wait_for

   task automatic do_reset(input logic s, input logic m, input logic all);
      tick(1);
      standalone_pin_i <= s;
      midspan_pin_i <= m;
      reset_all_i <= all;
      srst_i <= !all;
      tick(3);
      reset_all_i <= 1'b0;
      srst_i <= 1'b0;
      settle(3);
   endtask : do_reset

   function automatic logic [19:0] thr(input logic [2:0] c);
      case (c)
         3'h1: return {10'h070, 10'h1a9};
         3'h2: return {10'h0ce, 10'h1a9};
         3'h4: return {10'h27e, 10'h352};
         default: return {10'h177, 10'h1a9};
      endcase
   endfunction : thr

   initial begin
      void'($urandom(16502));
      dly <= 4'($urandom_range(9, 1));
      tick(2);
      srst_i <= 1'b0;
      settle(3);
      chk_v(overload_threshold_o[0], 10'h177);
      chk_v(current_limit_threshold_o[0], 10'h1a9);
      chk_v(10'({standalone_mode_o, sense_quarter_ohm_o, dc_disc_en_o, ac_disc_en_o}), 10'h000);
      // host enables detection before any port leaves shutdown
      detect_en_i <= 4'hf;
      class_en_i <= 4'h4;
      dres <= {3'h4, 3'h4, 3'($urandom_range(7)), 3'h4};
      cres <= {3'h0, 3'h1, 3'($urandom_range(4)), 3'h0};
      tick(1);
      port_mode_field_i <= {2'h3, 2'h2, 2'h1, 2'h0};
      send(1, 0);
      wait_for(4'h2, 0);
      settle(12);
      chk_v(10'(detect_status_o[1]), 10'(dres[1]));
      send(1, 1);
      wait_for(4'h2, 1);
      settle(12);
      chk_v(10'(class_status_o[1]), 10'(cres[1]));
      settle(100);
      chk_v(10'(nst[1]), 10'h001);
      chk_v(10'(nst[0] + nst[3]), 10'h000);
      chk_v(10'(nst[2] > 2), 10'h001);
      chk_v(10'(detect_status_o[2]), 10'h004);
      chk_v(10'(class_status_o[2]), 10'h001);
      chk_v(10'(power_on_o), 10'h000);
      chk_v(overload_threshold_o[2], 10'h177);
      for (int p = 0; p < PORTS; p++) send(p, 2);
      chk_v(10'(power_on_o), 10'h006);
      send(1, 3);
      chk_v(10'(power_on_o[1]), 10'h000);
      flt[2] <= 1'b1;
      settle(2);
      chk_v(10'(power_on_o[2]), 10'h000);
      flt[2] <= 1'b0;
      for (int w = 0; w < 2; w++) begin
         tick(1);
         disc_wdata_i <= 4'($urandom) | 4'h4;
         dc_disc_wr_i <= (w == 0);
         ac_disc_wr_i <= (w == 1);
         tick(1);
         dc_disc_wr_i <= 1'b0;
         ac_disc_wr_i <= 1'b0;
         settle(1);
         chk_v(10'({dc_disc_en_o, ac_disc_en_o}), 10'({disc_wdata_i, disc_wdata_i}));
      end
      send(2, 2);
      dsc[2] <= 1'b1;
      settle(2);
      chk_v(10'(power_on_o[2]), 10'h000);
      dsc[2] <= 1'b0;
      high_power_en_i <= 4'h4;
      dres[2] <= 3'h1;
      wait_for(4'h4, 0);
      settle(12);
      send(2, 2);
      chk_v(10'({startup_fault_o[2], power_on_o[2]}), 10'h002);
      dres[2] <= 3'h4;
      wait_for(4'h4, 0);
      settle(12);
      send(2, 2);
      chk_v(10'({startup_fault_o[2], power_on_o[2]}), 10'h001);
      sense_wdata_i <= 1'b1;
      sense_wr_i <= 1'b1;
      tick(1);
      sense_wr_i <= 1'b0;
      settle(1);
      chk_v(10'(sense_quarter_ohm_o), 10'h001);
      // standalone pin stays high for the whole standalone run
      port_mode_field_i <= {4{2'h3}};
      do_reset(1'b1, 1'b0, 1'b1);
      chk_v(10'({standalone_mode_o, sense_quarter_ohm_o, dc_disc_en_o, ac_disc_en_o}), 10'h3ff);
      cres <= {3'($urandom_range(4)), 3'($urandom_range(4)), 3'h0, 3'h4};
      detect_en_i <= 4'h0;
      wait_for(4'hf, 2);
      for (int p = 0; p < PORTS; p++) begin
         chk_v(overload_threshold_o[p], thr(cres[p])[19:10]);
         chk_v(current_limit_threshold_o[p], thr(cres[p])[9:0]);
      end
      midspan_pin_i <= 1'b1;
      settle(6);
      chk_v(10'(midspan_timing_o), 10'h000);
      send(0, 3);
      chk_v(10'(power_on_o[0]), 10'h000);
      port_mode_field_i <= {4{2'h2}};
      detect_en_i <= 4'hf;
      do_reset(1'b0, 1'b1, 1'b0);
      chk_v(10'(midspan_timing_o), 10'h001);
      settle(200);
      chk_v(10'(nst[2] > 4), 10'h001);
      print_verdict();
   end
endmodule : test_poe_port_mode_control
`default_nettype wire
